// file: hdl/slp_pkg.sv
/*
  Shared constants, carrier types and byte-lane helpers for the serial link
  host register port.
  Assumes one 25 MHz clock and the direct I/O bus handshake held by the host.
*/
package slp_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int BYTE_W = 8;

  // device addresses are strapped per installation; defaults are arbitrary
  localparam logic [15:0] CTRL_ADDR_DEF = 16'h0010;
  localparam logic [15:0] DATA_ADDR_DEF = 16'h0011;

  // control/status field positions: function bits low, status bits high
  localparam int CSR_BCNT_LSB   = 0;
  localparam int CSR_LEN_LSB    = 2;
  localparam int CSR_RSEL_BIT   = 4;
  localparam int CSR_LOOP_BIT   = 5;
  localparam int CSR_DTR_BIT    = 6;
  localparam int CSR_TXBUSY_BIT = 16;
  localparam int CSR_TXDONE_BIT = 17;
  localparam int CSR_CD_BIT     = 18;
  localparam int CSR_RXDONE_BIT = 19;
  localparam int CSR_PAR_BIT    = 20;
  localparam int CSR_OVR_BIT    = 21;
  localparam int CSR_FRM_BIT    = 22;

  localparam logic [31:0] CSR_FUNC_MASK = 32'h0000007F;
  localparam logic [31:0] CSR_RESET     = 32'h00000000;
  localparam logic [31:0] BUF_RESET     = 32'h00000000;

  typedef struct packed {
    logic        req;
    logic        wr;
    logic [15:0] addr;
    logic [31:0] wdata;
  } slp_dio_cmd_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] char;
    logic       parity_err;
    logic       framing_err;
  } slp_rx_char_t;

  typedef enum logic [2:0] {ST_IDLE, ST_SYNC, ST_DECODE, ST_ACT, ST_HOLD} slp_bus_state_t;

  // character slot idx counts from the most significant byte
  function automatic logic [7:0] lane_get(input logic [31:0] w, input logic [1:0] idx);
    lane_get = w[(31 - 8 * int'(idx)) -: 8];
  endfunction

  function automatic logic [31:0] lane_put(input logic [31:0] w, input logic [1:0] idx,
                                           input logic [7:0] b);
    logic [31:0] r;
    r = w;
    r[(31 - 8 * int'(idx)) -: 8] = b;
    lane_put = r;
  endfunction

  // length code 0..3 means 5..8 data bits, kept right-justified
  function automatic logic [7:0] char_mask(input logic [1:0] len);
    char_mask = 8'hFF >> (2'h3 - len);
  endfunction

endpackage

// file: hdl/slp_rx_packer.sv
/*
  Receive character packer: drops each incoming character into the next
  slot of the receive data buffer and pulses when the word is complete.
  Assumes the owner restarts it whenever the byte count may have changed.
*/
`timescale 1ns/1ps
module slp_rx_packer (
  input  wire logic        sys_clk_in,
  input  wire logic        reset_n_in,
  input  wire logic        char_valid_in,
  input  wire logic [7:0]  char_in,
  input  wire logic [1:0]  len_code_in,
  input  wire logic [1:0]  count_code_in,
  input  wire logic        restart_in,
  output logic      [31:0] buf_out,
  output logic             full_out
);

  logic [1:0] slot;
  logic [7:0] masked;
  logic       last_slot;

  assign masked    = char_in & slp_pkg::char_mask(len_code_in);
  // count code n means n+1 characters
  assign last_slot = (slot == count_code_in);

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      slot     <= 2'h0;
      buf_out  <= slp_pkg::BUF_RESET;
      full_out <= 1'b0;
    end else begin
      full_out <= 1'b0;
      if (restart_in) begin
        slot <= 2'h0;
      end else if (char_valid_in) begin
        buf_out  <= slp_pkg::lane_put(buf_out, slot, masked);
        slot     <= last_slot ? 2'h0 : slot + 2'h1;
        full_out <= last_slot;
      end
    end
  end

  AST_RX_FULL: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    (char_valid_in && !restart_in && last_slot) |=> (full_out && slot == 2'h0))
    else $error("receive word not completed at byte count");

  AST_RX_JUSTIFY: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    (char_valid_in && !restart_in && len_code_in == 2'h0) |=>
      (slp_pkg::lane_get(buf_out, $past(slot)) & 8'hE0) == 8'h00)
    else $error("short character not right-justified");

endmodule

// file: hdl/slp_host_port.sv
/*
  Host register port of the serial link peripheral on the direct I/O bus:
  control/status, transmit data and receive data registers behind two
  device addresses, plus the character feed to the transmitter.
  Assumes the host holds req, addr, wr and wdata until ack, then drops req.
*/
`timescale 1ns/1ps
module slp_host_port #(
  parameter logic [15:0] CTRL_ADDR = slp_pkg::CTRL_ADDR_DEF,
  parameter logic [15:0] DATA_ADDR = slp_pkg::DATA_ADDR_DEF
) (
  input  wire logic                  sys_clk_in,
  input  wire logic                  reset_n_in,
  input  wire slp_pkg::slp_dio_cmd_t dio_cmd_in,
  output logic                       dio_ack_out,
  output logic                [31:0] dio_rdata_out,
  output logic                       dio_data_oe_out,
  output logic                 [7:0] tx_char_out,
  output logic                       tx_valid_out,
  input  wire logic                  tx_ready_in,
  input  wire slp_pkg::slp_rx_char_t rx_char_in,
  input  wire logic                  carrier_detect_in,
  output logic                       dtr_out
);

  slp_pkg::slp_bus_state_t st;
  slp_pkg::slp_dio_cmd_t   cmd_q;

  logic        is_ctrl;
  logic [31:0] csr_func;
  logic [31:0] tx_buf;
  logic [31:0] rx_buf;
  logic [1:0]  tx_idx;
  logic        tx_pend;
  logic        tx_busy;
  logic        tx_done;
  logic        rx_done;
  logic        par_err;
  logic        ovr_err;
  logic        frm_err;

  logic        cmd_hit;
  logic        ctrl_wr_stb;
  logic        ctrl_rd_stb;
  logic        data_wr_stb;
  logic        data_rd_stb;
  logic [1:0]  bcnt;
  logic [1:0]  len_code;
  logic        read_select_bit;
  logic        loop_en;
  logic [31:0] csr_word;
  logic [31:0] rd_word;
  logic        tx_ready_eff;
  logic        tx_take;
  logic        tx_last;
  logic        next_tx_pend;
  logic        pk_valid;
  logic [7:0]  pk_char;
  logic        pk_full;
  logic        rx_ext_ok;
  logic        rx_clear;

  assign cmd_hit = dio_cmd_in.req &&
                   (dio_cmd_in.addr == CTRL_ADDR || dio_cmd_in.addr == DATA_ADDR);

  assign ctrl_wr_stb = (st == slp_pkg::ST_ACT) && is_ctrl && cmd_q.wr;
  assign ctrl_rd_stb = (st == slp_pkg::ST_ACT) && is_ctrl && !cmd_q.wr;
  assign data_wr_stb = (st == slp_pkg::ST_ACT) && !is_ctrl && cmd_q.wr;
  assign data_rd_stb = (st == slp_pkg::ST_ACT) && !is_ctrl && !cmd_q.wr;

  // byte count field steers both buffers
  assign bcnt            = csr_func[slp_pkg::CSR_BCNT_LSB +: 2];
  assign len_code        = csr_func[slp_pkg::CSR_LEN_LSB +: 2];
  assign read_select_bit = csr_func[slp_pkg::CSR_RSEL_BIT];
  assign loop_en         = csr_func[slp_pkg::CSR_LOOP_BIT];

  // software function bits beside live status
  assign csr_word = csr_func |
                    (32'(tx_busy)           << slp_pkg::CSR_TXBUSY_BIT) |
                    (32'(tx_done)           << slp_pkg::CSR_TXDONE_BIT) |
                    (32'(carrier_detect_in) << slp_pkg::CSR_CD_BIT) |
                    (32'(rx_done)           << slp_pkg::CSR_RXDONE_BIT) |
                    (32'(par_err)           << slp_pkg::CSR_PAR_BIT) |
                    (32'(ovr_err)           << slp_pkg::CSR_OVR_BIT) |
                    (32'(frm_err)           << slp_pkg::CSR_FRM_BIT);

  assign rd_word = is_ctrl ? csr_word : (read_select_bit ? tx_buf : rx_buf);

  // in loop-back tx_valid_out stays low (tx_char_out still carries each character) and characters go straight in
  assign tx_ready_eff = loop_en || tx_ready_in;
  assign tx_take      = tx_pend && tx_ready_eff;
  // last of one to four characters
  assign tx_last      = (tx_idx == bcnt);
  assign next_tx_pend = data_wr_stb ? 1'b0 :
                        (tx_pend && !tx_take) || (tx_busy && !tx_pend && !tx_take);

  // loop-back makes the receive buffer host writable
  assign pk_valid  = loop_en ? tx_take : rx_char_in.valid;
  assign pk_char   = loop_en ? tx_char_out : rx_char_in.char;
  assign rx_ext_ok = rx_char_in.valid && !loop_en;
  // receive flags hold until the host reads the buffer
  assign rx_clear  = data_rd_stb && !read_select_bit;

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st      <= slp_pkg::ST_IDLE;
      cmd_q   <= '0;
      is_ctrl <= 1'b0;
    end else begin
      unique case (st)
        slp_pkg::ST_IDLE: begin
          if (cmd_hit) begin
            cmd_q <= dio_cmd_in;
            st    <= slp_pkg::ST_SYNC;
          end
        end
        slp_pkg::ST_SYNC: begin
          st <= slp_pkg::ST_DECODE;
        end
        slp_pkg::ST_DECODE: begin
          is_ctrl <= (cmd_q.addr == CTRL_ADDR);
          st      <= slp_pkg::ST_ACT;
        end
        slp_pkg::ST_ACT: begin
          st <= slp_pkg::ST_HOLD;
        end
        slp_pkg::ST_HOLD: begin
          if (!dio_cmd_in.req) begin
            st <= slp_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // drive data and ack, release once req drops
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      dio_ack_out     <= 1'b0;
      dio_data_oe_out <= 1'b0;
      dio_rdata_out   <= 32'h00000000;
    end else if (st == slp_pkg::ST_ACT) begin
      dio_ack_out     <= 1'b1;
      dio_data_oe_out <= !cmd_q.wr;
      dio_rdata_out   <= cmd_q.wr ? 32'h00000000 : rd_word;
    end else if (st == slp_pkg::ST_HOLD && !dio_cmd_in.req) begin
      dio_ack_out     <= 1'b0;
      dio_data_oe_out <= 1'b0;
      dio_rdata_out   <= 32'h00000000;
    end
  end

  // control write loads function bits only
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      csr_func <= slp_pkg::CSR_RESET;
      dtr_out  <= 1'b0;
    end else if (ctrl_wr_stb) begin
      csr_func <= cmd_q.wdata & slp_pkg::CSR_FUNC_MASK;
      dtr_out  <= cmd_q.wdata[slp_pkg::CSR_DTR_BIT];
    end
  end

  // feed buffered characters to the transmitter
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tx_buf       <= slp_pkg::BUF_RESET;
      tx_idx       <= 2'h0;
      tx_pend      <= 1'b0;
      tx_busy      <= 1'b0;
      tx_done      <= 1'b0;
      tx_char_out  <= 8'h00;
      tx_valid_out <= 1'b0;
    end else begin
      tx_pend      <= next_tx_pend;
      tx_valid_out <= next_tx_pend && !loop_en;
      if (data_wr_stb) begin
        tx_buf  <= cmd_q.wdata;
        tx_idx  <= 2'h0;
        tx_busy <= 1'b1;
        tx_done <= 1'b0;
      end else if (tx_take) begin
        tx_idx <= tx_idx + 2'h1;
        if (tx_last) begin
          tx_busy <= 1'b0;
          tx_done <= 1'b1;
          tx_idx  <= 2'h0;
        end
      end
      if (tx_busy && !tx_pend && !data_wr_stb) begin
        tx_char_out <= slp_pkg::lane_get(tx_buf, tx_idx) & slp_pkg::char_mask(len_code);
      end
    end
  end

  // errors follow the receiver (overrun also loop-back data writes), never control writes
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rx_done <= 1'b0;
      par_err <= 1'b0;
      ovr_err <= 1'b0;
      frm_err <= 1'b0;
    end else begin
      // a set in the same cycle as the clearing read wins, except for overrun, which the clearing read blocks
      rx_done <= pk_full || (rx_done && !rx_clear);
      par_err <= (rx_ext_ok && rx_char_in.parity_err) || (par_err && !rx_clear);
      frm_err <= (rx_ext_ok && rx_char_in.framing_err) || (frm_err && !rx_clear);
      ovr_err <= (pk_valid && rx_done && !rx_clear) || (ovr_err && !rx_clear);
    end
  end

  slp_rx_packer u_rx_packer (
    .sys_clk_in    (sys_clk_in),
    .reset_n_in    (reset_n_in),
    .char_valid_in (pk_valid),
    .char_in       (pk_char),
    .len_code_in   (len_code),
    .count_code_in (bcnt),
    .restart_in    (ctrl_wr_stb),
    .buf_out       (rx_buf),
    .full_out      (pk_full)
  );

  AST_ACK_TIME: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    (st == slp_pkg::ST_IDLE && cmd_hit) |-> !dio_ack_out ##4 dio_ack_out)
    else $error("ack not four cycles after hit");

  AST_FOREIGN: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    (st == slp_pkg::ST_IDLE && dio_cmd_in.req && !cmd_hit) |=>
      (st == slp_pkg::ST_IDLE && !dio_ack_out && !dio_data_oe_out && $stable(csr_func)))
    else $error("foreign address touched the port");

  AST_RELEASE: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    (dio_ack_out && !dio_cmd_in.req) |=> (!dio_ack_out && !dio_data_oe_out))
    else $error("bus not released after req drop");

  AST_CSR_WRITE: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    ctrl_wr_stb |=> csr_func == ($past(cmd_q.wdata) & slp_pkg::CSR_FUNC_MASK))
    else $error("control write not loaded");

  AST_ERR_KEEP: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    (ctrl_wr_stb && !rx_char_in.valid && !pk_valid) |=>
      {par_err, frm_err, ovr_err} == $past({par_err, frm_err, ovr_err}))
    else $error("host write changed error flags");

  AST_TX_LOAD: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    data_wr_stb |=> (tx_buf == $past(cmd_q.wdata) && tx_busy && tx_idx == 2'h0))
    else $error("data write not loaded");

  AST_CSR_READ: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    ctrl_rd_stb |=> (dio_rdata_out == $past(csr_word) && dio_data_oe_out))
    else $error("control read wrong");

  AST_DATA_READ: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    data_rd_stb |=>
      dio_rdata_out == ($past(read_select_bit) ? $past(tx_buf) : $past(rx_buf)))
    else $error("data read picked wrong buffer");

  AST_TX_END: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    (tx_take && tx_last && !data_wr_stb) |=> (!tx_busy && tx_done))
    else $error("send did not end at byte count");

  COV_CTRL_WR: cover property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    ctrl_wr_stb ##1 dio_ack_out);
  COV_TX_READBACK: cover property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    data_rd_stb && read_select_bit);
  COV_RX_FULL: cover property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    pk_full ##[1:40] rx_clear);
  COV_LOOP: cover property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    loop_en && tx_take && tx_last);

endmodule

// file: verif/slp_line_model.sv
/*
  Behavioural model of the serial side facing the host port: a character
  sink for the transmitter feed and a source of received characters.
  Assumes the bench calls send_char and reads got_q by hierarchy.
*/
`timescale 1ns/1ps
module slp_line_model (
  input  wire logic            sys_clk_in,
  input  wire logic            tx_valid_in,
  input  wire logic      [7:0] tx_char_in,
  input  wire logic            stall_in,
  output logic                 tx_ready_out,
  output slp_pkg::slp_rx_char_t rx_char_out
);
  logic [7:0] got_q[$];
  logic [1:0] stall_cnt;

  initial begin
    tx_ready_out = 1'b0;
    rx_char_out  = '0;
    stall_cnt    = 2'h0;
  end

  // slow mode accepts only one edge in four, prompt mode every edge
  always @(negedge sys_clk_in) begin
    stall_cnt    <= stall_cnt + 2'h1;
    tx_ready_out <= stall_in ? (stall_cnt == 2'h3) : 1'b1;
  end

  always @(posedge sys_clk_in) begin
    if (tx_valid_in && tx_ready_out) begin
      got_q.push_back(tx_char_in);
    end
  end

  // idle char lines show the inverse so a stale value never matches
  task automatic send_char(input logic [7:0] b, input logic perr, input logic ferr);
    @(negedge sys_clk_in);
    rx_char_out = '{1'b1, b, perr, ferr};
    @(negedge sys_clk_in);
    rx_char_out = '{1'b0, ~b, 1'b0, 1'b0};
  endtask
endmodule

// file: verif/slp_host_port_test.sv
/*
  Self-checking bench for the host register port: direct I/O reads and
  writes with expected values, transmit feed and receive packing.
  Assumes slp_pkg, slp_host_port and slp_line_model are compiled first.
*/
`timescale 1ns/1ps
module slp_host_port_test;
  localparam logic [15:0] CA = 16'h0010;
  localparam logic [15:0] DA = 16'h0011;
  localparam logic [31:0] WORD = 32'hA1B2C3D4;

  logic                  sys_clk;
  logic                  reset_n;
  logic                  carrier;
  logic                  stall;
  slp_pkg::slp_dio_cmd_t cmd;
  slp_pkg::slp_rx_char_t rx_char;
  logic                  ack;
  logic                  oe;
  logic                  tx_valid;
  logic                  tx_ready;
  logic                  dtr;
  logic [7:0]            tx_char;
  logic [31:0]           rdata;
  logic [31:0]           rd;
  logic [31:0]           func;
  int                    error_cnt;
  int                    check_count;
  int                    k;

  slp_host_port #(.CTRL_ADDR(CA), .DATA_ADDR(DA)) i_dut (
    .sys_clk_in        (sys_clk),
    .reset_n_in        (reset_n),
    .dio_cmd_in        (cmd),
    .dio_ack_out       (ack),
    .dio_rdata_out     (rdata),
    .dio_data_oe_out   (oe),
    .tx_char_out       (tx_char),
    .tx_valid_out      (tx_valid),
    .tx_ready_in       (tx_ready),
    .rx_char_in        (rx_char),
    .carrier_detect_in (carrier),
    .dtr_out           (dtr)
  );

  slp_line_model i_line (
    .sys_clk_in   (sys_clk),
    .tx_valid_in  (tx_valid),
    .tx_char_in   (tx_char),
    .stall_in     (stall),
    .tx_ready_out (tx_ready),
    .rx_char_out  (rx_char)
  );

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  task automatic wrap_up;
    $display("checks=%0d errors=%0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // request held until ack is seen, then dropped; ack must then fall
  task automatic bus(input logic is_wr, input logic [15:0] a, input logic [31:0] wd, output logic [31:0] r);
    int n;
    n = 0;
    @(negedge sys_clk);
    cmd = '{1'b1, is_wr, a, wd};
    do begin
      @(negedge sys_clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    r = rdata;
    chk(32'd4, n);
    chk({31'h0, ~is_wr}, {31'h0, oe});
    cmd.req = 1'b0;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (ack !== 1'b0 && n < 20);
    chk(32'd1, n);
  endtask

  initial begin
    #(40 * 20000);
    error_cnt++;
    wrap_up;
  end

  initial begin
    cmd = '0;
    carrier = 1'b0;
    stall = 1'b0;
    reset_n = 1'b0;
    error_cnt = 0;
    check_count = 0;
    repeat (12) @(negedge sys_clk);
    reset_n = 1'b1;
    bus(1'b0, CA, 32'h0, rd);
    chk(32'h0, rd);
    bus(1'b0, DA, 32'h0, rd);
    chk(32'h0, rd);
    // foreign address: no answer, no change
    @(negedge sys_clk);
    cmd = '{1'b1, 1'b1, 16'h0012, 32'hFFFFFFFF};
    repeat (8) begin
      @(negedge sys_clk);
      chk(32'h0, {30'h0, ack, oe});
    end
    cmd.req = 1'b0;
    bus(1'b0, CA, 32'h0, rd);
    chk(32'h0, rd);
    bus(1'b1, CA, 32'hFFFFFFFF, rd);
    bus(1'b0, CA, 32'h0, rd);
    chk(32'h0000007F, rd);
    chk(32'h1, {31'h0, dtr});
    // every count, each with a length code equal to the count, with the far side stalling
    stall = 1'b1;
    for (int n = 0; n < 4; n++) begin
      func = {27'h0, 1'b1, n[1:0], n[1:0]};
      bus(1'b1, CA, func, rd);
      i_line.got_q.delete();
      bus(1'b1, DA, WORD, rd);
      k = 0;
      do begin
        bus(1'b0, CA, 32'h0, rd);
        k++;
      end while (rd[17] !== 1'b1 && k < 60);
      chk(func | 32'h00020000, rd);
      chk(n + 1, i_line.got_q.size());
      foreach (i_line.got_q[j]) begin
        chk({24'h0, WORD[31 - 8 * j -: 8] & (8'hFF >> (3 - n))}, {24'h0, i_line.got_q[j]});
      end
      bus(1'b0, DA, 32'h0, rd);
      chk(WORD, rd);
    end
    // receive two chars, second with a parity error
    stall = 1'b0;
    carrier = 1'b1;
    bus(1'b1, CA, 32'h00000001, rd);
    i_line.send_char(8'h5A, 1'b0, 1'b0);
    i_line.send_char(8'h3C, 1'b1, 1'b0);
    repeat (4) @(negedge sys_clk);
    // try to set overrun and framing from the host side
    bus(1'b1, CA, 32'h00E00001, rd);
    bus(1'b0, CA, 32'h0, rd);
    chk(32'h001E0001, rd);
    bus(1'b0, DA, 32'h0, rd);
    chk(32'h1A1C0000, rd);
    bus(1'b0, CA, 32'h0, rd);
    chk(32'h00060001, rd);
    // loop-back: transmit word lands in the receive buffer, tx_valid stays low
    i_line.got_q.delete();
    bus(1'b1, CA, 32'h0000002F, rd);
    bus(1'b1, DA, WORD, rd);
    k = 0;
    do begin
      bus(1'b0, CA, 32'h0, rd);
      k++;
    end while (rd[17] !== 1'b1 && k < 60);
    chk(32'h0, i_line.got_q.size());
    bus(1'b0, DA, 32'h0, rd);
    chk(WORD, rd);
    bus(1'b0, CA, 32'h0, rd);
    chk(32'h0006002F, rd);
    wrap_up;
  end
endmodule
